/* rtl/tmr_pkg.sv */
// Purpose: constants and carriers for the 8-bit timer with shared prescaler
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register byte address is four times the register index
// Behaviour
// (RQ1) eight-bit timer count, read and write
// (RQ2) source select clear: count instruction cycles
// (RQ3) count write stalls counting two instruction cycles
// (RQ4) source select set: count pin edges, edge chosen
// (RQ5) wrap from ff to 00 sets flag
// (RQ6) flag interrupts only when enabled; software clears
// (RQ7) timer stops during sleep
// (RQ8) unassigned prescaler: pin passes straight through
// (RQ9) prescaler output sampled in phases two, four
// (RQ10) pin high and low two oscillator periods
// (RQ11) assign bit routes prescaler: timer or watchdog
// (RQ12) rate field sets ratio, doubling each step
// (RQ13) prescaler is hidden eight-bit counter
// (RQ14) count write clears prescaler when timer-assigned
// (RQ15) watchdog clear clears prescaler when watchdog-assigned
// (RQ16) software sequence when moving prescaler to watchdog
// (RQ17) clear watchdog first when moving back to timer
// (RQ18) timer advances per synchronised prescaler output pulse
package tmr_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int          ADDR_W        = 12;
    localparam logic [7:0]  IDX_COUNT     = 8'h01;
    localparam logic [7:0]  IDX_OPTION    = 8'h81;
    localparam logic [7:0]  IDX_STATUS    = 8'h82;
    localparam logic [7:0]  IDX_MASK      = 8'h83;
    localparam logic [7:0]  IDX_CONTROL   = 8'h84;
    localparam logic [7:0]  OPTION_RST    = 8'hff;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int          OPT_SRC_SEL   = 5;
    localparam int          OPT_EDGE_SEL  = 4;
    localparam int          OPT_ASSIGN    = 3;
    localparam int          OPT_RATE_LSB  = 0;
    localparam int          STAT_OVF      = 0;
    localparam int          CTRL_SLEEP    = 0;
    localparam int          CTRL_WDT_CLR  = 1;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          PHASES        = 4;
    localparam int          INHIBIT_INSTR = 2;
    localparam logic [1:0]  PH_Q2         = 2'd1;
    localparam logic [1:0]  PH_Q4         = 2'd3;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;
endpackage

/* rtl/timer_prescaled.sv */
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog
// Assumes: ext_count_input is asynchronous; wdt_tick is on clk_sys
// Notes:   apb answers with no wait state, read data from flops
//          byte address is four times the index: count 0x004,
//          option 0x204, status 0x208, mask 0x20c, control 0x210
//          control bit 0 freezes timer and prescaler while set
//          control bit 1 clears the prescaler when the watchdog owns it
//          option bits 7 and 6 are stored but drive nothing
`timescale 1ns/1ps
`default_nettype none
module timer_prescaled
    import tmr_pkg::*;
#(
    parameter int INHIBIT_CYCLES = INHIBIT_INSTR
) (
    input  wire logic     clk_sys,
    input  wire logic     rstn,
    input  wire apb_req_s apb_req,
    output apb_rsp_s      apb_rsp,
    input  wire logic     ext_count_input,
    input  wire logic     wdt_tick,
    output logic          wdt_timeout,
    output logic          irq
);
    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (INHIBIT_CYCLES < 1 || INHIBIT_CYCLES > 3) begin : g_chk
        $error("INHIBIT_CYCLES must be 1 to 3");
    end

    // ----------------------------------------
    // package checks
    // ----------------------------------------
    // phase is a two-bit counter, so an instruction cycle is four clocks
    if (PHASES != 4) begin : g_chk_phases
        $error("PHASES must be 4");
    end
    // both sample phases must differ, or short pin pulses are missed
    if (PH_Q2 == PH_Q4) begin : g_chk_sample
        $error("sample phases must differ");
    end
    if (OPT_SRC_SEL > 7 || OPT_EDGE_SEL > 7 || OPT_ASSIGN > 7) begin : g_chk_opt
        $error("option bit outside the byte");
    end
    if (OPT_RATE_LSB + 3 > 8) begin : g_chk_rate
        $error("rate field outside the byte");
    end
    if (STAT_OVF > 7 || CTRL_SLEEP > 7 || CTRL_WDT_CLR > 7) begin : g_chk_bits
        $error("status or control bit outside the byte");
    end
    // the decoder reads paddr bits 11 to 10 as must-be-zero
    if (ADDR_W < 11) begin : g_chk_addr
        $error("ADDR_W too small for the register map");
    end
    if (INHIBIT_INSTR < 1 || INHIBIT_INSTR > 3) begin : g_chk_inhibit
        $error("INHIBIT_INSTR must be 1 to 3");
    end
    // overlapping indices would let one write land in two registers
    if (IDX_COUNT == IDX_OPTION || IDX_STATUS == IDX_MASK
        || IDX_MASK == IDX_CONTROL || IDX_COUNT == IDX_CONTROL) begin : g_chk_idx
        $error("register indices overlap");
    end

    typedef struct packed {
        logic [1:0] phase;
        logic       pin_s1;
        logic       pin_s2;
        logic       src_prev;
        logic [7:0] pre_cnt;
        logic       samp;
        logic [7:0] timer_count;
        logic [1:0] inhibit;
        logic [7:0] option;
        logic       overflow_flag;
        logic       overflow_irq_enable;
        logic       sleep;
        logic       wdt_out;
        logic       irq;
        apb_rsp_s   rsp;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic       setup;
    logic       wr_acc;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] rd_val;
    logic       src_lvl;
    logic       src_rise;
    logic       pre_out;
    logic [2:0] rate;
    logic       to_wdt;
    logic       wr_count;
    logic       wdt_clr;
    logic       samp_new;
    logic       bump;
    logic [7:0] wmask;
    logic       hit_count;
    logic       hit_option;
    logic       hit_status;
    logic       hit_mask;
    logic       hit_control;
    logic       hit_any;
    logic       we_count;
    logic       we_option;
    logic       we_status;
    logic       we_mask;
    logic       we_control;
    logic       pin_lvl;
    logic       instr_lvl;
    logic       q2_now;
    logic       q4_now;

    assign apb_rsp     = st_r.rsp;
    assign irq         = st_r.irq;
    assign wdt_timeout = st_r.wdt_out;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // upper address bits must be zero so aliases cannot reach a register
    assign setup       = apb_req.psel & ~apb_req.penable;
    assign wr_acc      = apb_req.psel & apb_req.penable & st_r.rsp.pready & apb_req.pwrite;
    assign idx         = apb_req.paddr[9:2];
    assign mapped      = (apb_req.paddr[ADDR_W-1:10] == '0)
                         && (apb_req.paddr[1:0] == 2'b00);
    assign hit_count   = mapped && (idx == IDX_COUNT);
    assign hit_option  = mapped && (idx == IDX_OPTION);
    assign hit_status  = mapped && (idx == IDX_STATUS);
    assign hit_mask    = mapped && (idx == IDX_MASK);
    assign hit_control = mapped && (idx == IDX_CONTROL);
    assign hit_any     = hit_count | hit_option | hit_status | hit_mask | hit_control;

    // ----------------------------------------
    // write strobes
    // ----------------------------------------
    // a write lands only at the edge that completes the access phase
    assign we_count    = wr_acc & hit_count;
    assign we_option   = wr_acc & hit_option;
    assign we_status   = wr_acc & hit_status;
    assign we_mask     = wr_acc & hit_mask;
    assign we_control  = wr_acc & hit_control;
    assign wr_count    = we_count;
    assign wdt_clr     = we_control & apb_req.pwdata[CTRL_WDT_CLR];

    // ----------------------------------------
    // count sources and phases
    // ----------------------------------------
    // edge select folds into the level so one rising detector serves both
    assign pin_lvl     = st_r.pin_s2 ^ st_r.option[OPT_EDGE_SEL];
    assign instr_lvl   = st_r.phase[1];
    assign rate        = st_r.option[OPT_RATE_LSB +: 3];
    assign to_wdt      = st_r.option[OPT_ASSIGN];
    assign q2_now      = (st_r.phase == PH_Q2);
    assign q4_now      = (st_r.phase == PH_Q4);

    always_comb begin
        st_nxt   = st_r;
        bump     = 1'b0;
        wmask    = 8'h00;
        rd_val   = 8'h00;

        // ----------------------------------------
        // phase clock and pin synchroniser
        // ----------------------------------------
        st_nxt.phase  = st_r.phase + 2'd1;
        st_nxt.pin_s1 = ext_count_input;
        st_nxt.pin_s2 = st_r.pin_s1;

        // (RQ4) pin edge choice
        // (RQ2) instruction clock as source
        src_lvl = st_r.option[OPT_SRC_SEL] ? pin_lvl : instr_lvl;
        src_rise        = src_lvl & ~st_r.src_prev;
        st_nxt.src_prev = src_lvl;

        // ----------------------------------------
        // shared prescaler
        // ----------------------------------------
        // (RQ8) undivided when watchdog owns it
        // (RQ12) timer ratio two to the rate plus one
        pre_out = to_wdt ? src_lvl : st_r.pre_cnt[rate];

        // (RQ13) hidden prescale counter
        // (RQ11) routed by assign bit
        st_nxt.wdt_out = 1'b0;
        if (!st_r.sleep) begin
            if (!to_wdt && src_rise) begin
                st_nxt.pre_cnt = st_r.pre_cnt + 8'd1;
            end else if (to_wdt && wdt_tick) begin
                // (RQ12) watchdog ratio two to the rate
                wmask = 8'((9'd1 << rate) - 9'd1);
                if ((st_r.pre_cnt & wmask) == wmask) begin
                    st_nxt.wdt_out = 1'b1;
                end
                st_nxt.pre_cnt = st_r.pre_cnt + 8'd1;
            end
        end
        // (RQ14) count write clears prescaler
        if (wr_count && !to_wdt) begin
            st_nxt.pre_cnt = 8'h00;
        end
        // (RQ15) watchdog clear clears prescaler
        if (wdt_clr && to_wdt) begin
            st_nxt.pre_cnt = 8'h00;
        end

        // ----------------------------------------
        // phase sampling
        // ----------------------------------------
        // (RQ9) sample in q2 and q4
        samp_new = st_r.samp;
        if (q2_now || q4_now) begin
            samp_new = pre_out;
        end
        st_nxt.samp = samp_new;

        // (RQ3) hold-off counts down at q4
        if (st_r.inhibit != 2'd0 && q4_now) begin
            st_nxt.inhibit = st_r.inhibit - 2'd1;
        end

        // ----------------------------------------
        // timer count
        // ----------------------------------------
        // (RQ18) advance per synchronised pulse
        // (RQ7) frozen during sleep
        if (samp_new && !st_r.samp && !st_r.sleep && st_r.inhibit == 2'd0) begin
            bump = 1'b1;
        end
        if (bump) begin
            st_nxt.timer_count = st_r.timer_count + 8'd1;
            // (RQ5) wrap sets flag
            if (st_r.timer_count == 8'hff) begin
                st_nxt.overflow_flag = 1'b1;
            end
        end

        // ----------------------------------------
        // apb register writes
        // ----------------------------------------
        if (we_count) begin
            // (RQ1) software load of count
            st_nxt.timer_count = apb_req.pwdata[7:0];
            // (RQ3) start two-cycle hold-off
            st_nxt.inhibit     = 2'(INHIBIT_CYCLES);
        end else if (we_option) begin
            // (RQ16) assignment may change any time
            st_nxt.option = apb_req.pwdata[7:0];
        end else if (we_status) begin
            // (RQ6) write one clears, overflow set wins
            if (apb_req.pwdata[STAT_OVF] && !(bump && st_r.timer_count == 8'hff)) begin
                st_nxt.overflow_flag = 1'b0;
            end
        end else if (we_mask) begin
            st_nxt.overflow_irq_enable = apb_req.pwdata[STAT_OVF];
        end else if (we_control) begin
            st_nxt.sleep = apb_req.pwdata[CTRL_SLEEP];
        end

        // ----------------------------------------
        // interrupt
        // ----------------------------------------
        // (RQ6) gated level interrupt
        st_nxt.irq = st_nxt.overflow_flag & st_nxt.overflow_irq_enable;

        // ----------------------------------------
        // apb read path and handshake
        // ----------------------------------------
        if (hit_count) begin
            rd_val = st_r.timer_count;
        end else if (hit_option) begin
            rd_val = st_r.option;
        end else if (hit_status) begin
            rd_val = {7'd0, st_r.overflow_flag};
        end else if (hit_mask) begin
            rd_val = {7'd0, st_r.overflow_irq_enable};
        end else if (hit_control) begin
            rd_val = {7'd0, st_r.sleep};
        end
        // answer registered during setup: no wait state, read data straight from a flop
        st_nxt.rsp.pready = setup;
        if (setup) begin
            st_nxt.rsp.prdata  = {24'd0, rd_val};
            st_nxt.rsp.pslverr = !hit_any;
        end else begin
            st_nxt.rsp.prdata  = 32'h0000_0000;
            st_nxt.rsp.pslverr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r                     <= '0;
            st_r.option              <= OPTION_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // timer_prescaled
`default_nettype wire

/* verif/timer_properties.sv */
// Purpose: port checks for the prescaled timer
// Assumes: apb answers in the cycle after setup
// Notes:   timer internals are hidden, so checks sit on bus, irq and watchdog timeout
`timescale 1ns/1ps
`default_nettype none
module timer_properties
    import tmr_pkg::*;
(
    input wire logic     clk_sys,
    input wire logic     rstn,
    input wire apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp,
    input wire logic     ext_count_input,
    input wire logic     wdt_tick,
    input wire logic     wdt_timeout,
    input wire logic     irq
);
    // ----------------------------------------
    // bus, interrupt and watchdog relations
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic setup  = apb_req.psel && !apb_req.penable;
    wire logic mapped = apb_req.paddr inside {12'h004, 12'h204, 12'h208, 12'h20c, 12'h210};
    property p_ready; setup |=> apb_rsp.pready ##1 !apb_rsp.pready; endproperty
    a_ready: assert property (p_ready) else $error("answer not one cycle after setup");
    property p_cause; apb_rsp.pready |-> $past(setup) && apb_req.penable; endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_err; setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; setup && mapped |=> !apb_rsp.pslverr && apb_rsp.prdata[31:8] == 0; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused or wide");
    property p_idle; !apb_rsp.pready |-> apb_rsp.prdata == 0 && !apb_rsp.pslverr; endproperty
    a_idle: assert property (p_idle) else $error("response outside access");
    // flag is sticky: only a bus write can take irq down
    property p_hold; irq && !apb_req.psel && !$past(apb_req.psel) |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("irq dropped without write");
    property p_fall; $fell(irq) |-> $past(apb_req.psel) || $past(apb_req.psel, 2); endproperty
    a_fall: assert property (p_fall) else $error("irq fell without access");
    property p_wdt; wdt_timeout |-> $past(wdt_tick) || $past(wdt_tick, 2); endproperty
    a_wdt: assert property (p_wdt) else $error("timeout without tick");
endmodule // timer_properties

bind timer_prescaled timer_properties chk (.clk_sys(clk_sys), .rstn(rstn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .ext_count_input(ext_count_input),
    .wdt_tick(wdt_tick), .wdt_timeout(wdt_timeout), .irq(irq));
`default_nettype wire

/* verif/count_source.sv */
// Purpose: external count source on the pin
// Assumes: driven only when the bench asks for pulses
// Notes:   rests low between bursts
`timescale 1ns/1ps
`default_nettype none
module count_source (
    input  wire logic clk_sys,
    output var logic  pin
);
    initial pin = 1'b0;
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys) pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask
endmodule // count_source
`default_nettype wire

/* verif/timer0_with_shared_prescaler_test.sv */
// Purpose: register-level tests of the prescaled timer
// Assumes: apb master, bench owns the watchdog tick
// Notes:   rate windows are whole prescaler periods, so phase drops out
`timescale 1ns/1ps
`default_nettype none
module timer0_with_shared_prescaler_test
    import tmr_pkg::*;
;
    logic        clk_sys = 1'b0, rstn = 1'b0, wdt_tick = 1'b0;
    apb_req_s    apb_req = '0;
    apb_rsp_s    apb_rsp;
    logic        ext_count_input, wdt_timeout, irq, err;
    logic [31:0] rd, r1;
    logic [15:0] cm [3] = '{16'h2855, 16'h3855, 16'h2042};
    int          err_total = 0, compares = 0, tmo = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wdt_timeout === 1'b1) tmo <= tmo + 1;
    timer_prescaled dut (.clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .ext_count_input(ext_count_input), .wdt_tick(wdt_tick),
        .wdt_timeout(wdt_timeout), .irq(irq));
    count_source src (.clk_sys(clk_sys), .pin(ext_count_input));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    // pready is read at the rising edge, before the design's update lands
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys) apb_req <= {1'b1, 1'b0, w, a, 24'h00_0000, d};
        @(posedge clk_sys) apb_req.penable <= 1'b1;
        do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rate(input logic [7:0] opt, input int cyc, input logic [7:0] inc);
        xfer(1'b1, ad(IDX_OPTION), opt);
        xfer(1'b1, ad(IDX_COUNT), 8'h00);
        repeat (20) @(posedge clk_sys);
        xfer(1'b0, ad(IDX_COUNT), 8'h00);
        r1 = rd;
        repeat (cyc - 3) @(posedge clk_sys);
        xfer(1'b0, ad(IDX_COUNT), 8'h00);
        chk("count step", rd[7:0] - r1[7:0], inc);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys) wdt_tick <= 1'b1;
            @(posedge clk_sys) wdt_tick <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    task automatic finish_test;
        if (err_total == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        xfer(1'b0, ad(IDX_OPTION), 8'h00);
        chk("option reset", rd[7:0], 8'hff);
        xfer(1'b0, 12'h100, 8'h00);
        chk("unmapped", {7'h00, err}, 8'h01);
        for (int r = 0; r < 8; r++) rate(8'(r), 16 << r, 8'h02);
        rate(8'h08, 32, 8'h08);
        xfer(1'b1, ad(IDX_COUNT), 8'ha5);
        repeat (5) @(posedge clk_sys);
        xfer(1'b0, ad(IDX_COUNT), 8'h00);
        chk("count hold", rd[7:0], 8'ha5);
        xfer(1'b1, ad(IDX_MASK), 8'h00);
        xfer(1'b1, ad(IDX_COUNT), 8'hfd);
        repeat (40) @(negedge clk_sys);
        chk("irq masked", {7'h00, irq}, 8'h00);
        xfer(1'b0, ad(IDX_STATUS), 8'h00);
        chk("flag", rd[7:0], 8'h01);
        xfer(1'b1, ad(IDX_MASK), 8'h01);
        repeat (3) @(negedge clk_sys);
        chk("irq on", {7'h00, irq}, 8'h01);
        xfer(1'b1, ad(IDX_STATUS), 8'h01);
        repeat (3) @(negedge clk_sys);
        chk("irq off", {7'h00, irq}, 8'h00);
        xfer(1'b1, ad(IDX_CONTROL), 8'h01);
        xfer(1'b0, ad(IDX_COUNT), 8'h00);
        r1 = rd;
        repeat (50) @(posedge clk_sys);
        xfer(1'b0, ad(IDX_COUNT), 8'h00);
        chk("sleep", rd[7:0], r1[7:0]);
        xfer(1'b1, ad(IDX_CONTROL), 8'h00);
        foreach (cm[i]) begin
            xfer(1'b1, ad(IDX_CONTROL), 8'h02);
            xfer(1'b1, ad(IDX_OPTION), cm[i][15:8]);
            xfer(1'b1, ad(IDX_COUNT), 8'h00);
            repeat (12) @(posedge clk_sys);
            src.pulses(int'(cm[i][7:4]));
            repeat (6) @(posedge clk_sys);
            xfer(1'b0, ad(IDX_COUNT), 8'h00);
            chk("pin count", rd[7:0], {4'h0, cm[i][3:0]});
        end
        xfer(1'b1, ad(IDX_CONTROL), 8'h02);
        xfer(1'b1, ad(IDX_COUNT), 8'h00);
        xfer(1'b1, ad(IDX_OPTION), 8'h09);
        tick(5);
        xfer(1'b1, ad(IDX_CONTROL), 8'h02);
        tick(1);
        repeat (4) @(negedge clk_sys);
        chk("timeouts", 8'(tmo), 8'h02);
        finish_test;
    end
endmodule // timer0_with_shared_prescaler_test
`default_nettype wire
